/* File: src/sfam_pkg.sv */
package sfam_pkg;

  // Number of latched fault sources handled by the block.
  localparam int NUM_FAULTS = 26;

  // Bit index of each fault in the fault vector.
  localparam int F_MOTOR_OPEN = 0;
  localparam int F_RELAY_WELD = 1;
  localparam int F_RELAY_NOCLOSE = 2;
  localparam int F_CMD1_RANGE = 3;
  localparam int F_CMD2_RANGE = 4;
  localparam int F_FB1_RANGE = 5;
  localparam int F_FB2_RANGE = 6;
  localparam int F_NMT_LATE = 7;
  localparam int F_NV_FAIL = 8;
  localparam int F_PARAM_CHANGE = 9;
  localparam int F_INTLK_SUP = 10;
  localparam int F_HOME_SW_SUP = 11;
  localparam int F_HOME_NOT_FOUND = 12;
  localparam int F_HOME_TOL = 13;
  localparam int F_CMD_SUP = 14;
  localparam int F_POS_SUP = 15;
  localparam int F_SW_FAULT = 16;
  localparam int F_PERIODIC_LOST = 17;
  localparam int F_FOLLOW_ERR = 18;
  localparam int F_HW_FAULT = 19;
  localparam int F_PARAM_CONFLICT = 20;
  localparam int F_BUS_LOAD = 21;
  localparam int F_PDO_MAP = 22;
  localparam int F_BAD_CAL = 23;
  localparam int F_PARAM_RANGE = 24;
  localparam int F_SUPERVISOR = 25;

  // Flash code of each fault, element i belongs to fault bit i.
  localparam logic [NUM_FAULTS-1:0][6:0] FLASH_CODES = {
    7'h54, 7'h52, 7'h51, 7'h4f, 7'h4e, 7'h4b, 7'h4a, 7'h49, 7'h48, 7'h47,
    7'h38, 7'h37, 7'h36, 7'h35, 7'h34, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c,
    7'h2b, 7'h2a, 7'h29, 7'h27, 7'h26, 7'h25};

  // Steering action class of each fault; together they cover every bit once.
  localparam logic [NUM_FAULTS-1:0] SHUT_MASK = 26'h3dd3306;
  localparam logic [NUM_FAULTS-1:0] HOLD_MASK = 26'h000c078;
  localparam logic [NUM_FAULTS-1:0] WARN_MASK = 26'h0220881;
  localparam logic [NUM_FAULTS-1:0] INTLK_MASK = 26'h0000400;

  // Timing figures.
  localparam int CLK_KHZ = 250000;
  localparam int NMT_TIMEOUT_MS = 80;
  localparam int PERIODIC_TIMEOUT_MS = 100;
  localparam logic [6:0] NO_CODE = 7'h00;

  // Steering action state.
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_WARN,
    ST_HOLD,
    ST_SHUTDOWN
  } sfam_state_type;

endpackage

/* File: src/sfam_fault_latch.sv */
`timescale 1ns/1ns
// Sticky fault flags; only a power-on reset (key switch cycle) clears them.
module sfam_fault_latch #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] set_i,
  output logic [WIDTH-1:0] flag_o
);

  // A flag, once set, is never cleared by anything but reset.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= flag_o | set_i;
    end
  end

endmodule

/* File: src/sfam_manager.sv */
`timescale 1ns/1ns
// Functional notes
// RULE1: Motor open: code 37, warn-then-shutdown, stop traction.
// RULE2: Relay welded 38, not closed 39: shutdown.
// RULE3: Command input 1 range: code 41, hold.
// RULE4: Command 2 range or crosscheck: code 42, hold.
// RULE5: Feedback input 1 range: code 43, hold.
// RULE6: Feedback 2 range or crosscheck: code 44, hold.
// RULE7: Network operational within 80 ms, else 45.
// RULE8: Memory failure: code 46, immediate shutdown.
// RULE9: Power-cycle parameter change or restore: 47.
// RULE10: Interlock inputs mismatch: code 51, interlock off.
// RULE11: Home switches compared away from home: 52.
// RULE12: Home not found 53, tolerance 54: shutdown.
// RULE13: Command supervision 55, position 56: hold.
// RULE14: Software 71, hardware 74, supervisor 84: shutdown.
// RULE15: Periodic traction messages halted: code 72, warn.
// RULE16: Following error: code 73, immediate shutdown.
// RULE17: Conflicting parameter selections: code 75, shutdown.
// RULE18: Bus overload or fast sending: 78, warn.
// RULE19: Bad process data mapping: code 79, shutdown.
// RULE20: Calibration 81, parameter range 82: shutdown.
// RULE21: Shutdown stops steering, drops fault output.
// RULE22: Warn: run until traction stops or timeout.
// RULE23: Hold: freeze position until stop or timeout.
// RULE24: Faults latch until key switch power cycles.
// RULE25: Most severe action wins among active faults.
module sfam_manager #(
  parameter int MS_CYCLES = sfam_pkg::CLK_KHZ,
  parameter int NMT_TIMEOUT_CYC = sfam_pkg::NMT_TIMEOUT_MS * sfam_pkg::CLK_KHZ,
  parameter int PERIODIC_TIMEOUT_CYC = sfam_pkg::PERIODIC_TIMEOUT_MS * sfam_pkg::CLK_KHZ
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic motor_open_i,
  input wire logic relay_welded_i,
  input wire logic relay_no_close_i,
  input wire logic cmd1_out_of_range_i,
  input wire logic cmd2_out_of_range_i,
  input wire logic cmd_crosscheck_fail_i,
  input wire logic fb1_out_of_range_i,
  input wire logic fb2_out_of_range_i,
  input wire logic fb_crosscheck_fail_i,
  input wire logic nmt_operational_i,
  input wire logic nv_fail_i,
  input wire logic param_change_i,
  input wire logic param_restore_i,
  input wire logic interlock_sw_a_i,
  input wire logic interlock_sw_b_i,
  input wire logic near_home_i,
  input wire logic home_sw_a_i,
  input wire logic home_sw_b_i,
  input wire logic home_not_found_i,
  input wire logic home_tolerance_fail_i,
  input wire logic cmd_supervision_fail_i,
  input wire logic pos_supervision_fail_i,
  input wire logic software_fault_i,
  input wire logic hardware_fault_i,
  input wire logic supervisor_fault_i,
  input wire logic traction_periodic_message_i,
  input wire logic following_error_i,
  input wire logic param_conflict_i,
  input wire logic bus_overload_i,
  input wire logic pdo_mapping_error_i,
  input wire logic bad_calibration_i,
  input wire logic param_out_of_range_i,
  input wire logic traction_stopped_i,
  input wire logic [15:0] fault_steer_timeout_ms_i,
  output logic steer_enable_o,
  output logic hold_position_o,
  output logic fault_output_o,
  output logic interlock_enable_o,
  output logic traction_stop_req_o,
  output logic fault_active_o,
  output logic [6:0] flash_code_o,
  output logic [sfam_pkg::NUM_FAULTS-1:0] fault_vector_o
);

  localparam int NF = sfam_pkg::NUM_FAULTS;

  logic [NF-1:0] set_d;
  logic [NF-1:0] flt_q;
  logic intlk_applied;
  logic intlk_applied_q;
  logic nmt_run_q;
  logic [24:0] nmt_cnt_q;
  logic nmt_expired;
  logic pd_seen_q;
  logic [24:0] pd_cnt_q;
  logic pd_expired;
  logic [17:0] ms_div_q;
  logic ms_tick_q;
  logic [15:0] act_ms_q;
  logic act_timeout;
  logic any_shut;
  logic any_hold;
  logic any_warn;
  sfam_pkg::sfam_state_type state_q;
  sfam_pkg::sfam_state_type state_d;
  logic [6:0] code_d;

  // The interlock counts as applied only while both redundant switches agree on.
  assign intlk_applied = interlock_sw_a_i & interlock_sw_b_i;

  // Network start-up watchdog: runs from the interlock edge until operational.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      intlk_applied_q <= 1'b0;
      nmt_run_q <= 1'b0;
      nmt_cnt_q <= 25'h0000000;
    end else begin
      intlk_applied_q <= intlk_applied;
      if (intlk_applied && !intlk_applied_q && !nmt_operational_i) begin
        nmt_run_q <= 1'b1;
        nmt_cnt_q <= 25'h0000000;
      end else if (nmt_run_q && (nmt_operational_i || nmt_expired)) begin
        nmt_run_q <= 1'b0;
      end else if (nmt_run_q) begin
        nmt_cnt_q <= nmt_cnt_q + 25'h0000001;
      end
    end
  end

  assign nmt_expired = nmt_run_q && !nmt_operational_i && (nmt_cnt_q == 25'(NMT_TIMEOUT_CYC - 1)); // [RULE7]

  // Periodic message watchdog: armed by the first message, so a bus that never started is not flagged here.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pd_seen_q <= 1'b0;
      pd_cnt_q <= 25'h0000000;
    end else if (traction_periodic_message_i) begin
      pd_seen_q <= 1'b1;
      pd_cnt_q <= 25'h0000000;
    end else if (pd_seen_q && !pd_expired) begin
      pd_cnt_q <= pd_cnt_q + 25'h0000001;
    end
  end

  assign pd_expired = pd_seen_q && (pd_cnt_q == 25'(PERIODIC_TIMEOUT_CYC - 1)); // [RULE15]

  // Fault detection; each bit is a one-cycle or level set request.
  always_comb begin
    set_d = '0;
    set_d[sfam_pkg::F_MOTOR_OPEN] = motor_open_i; // [RULE1]
    set_d[sfam_pkg::F_RELAY_WELD] = relay_welded_i; // [RULE2]
    set_d[sfam_pkg::F_RELAY_NOCLOSE] = relay_no_close_i; // [RULE2]
    set_d[sfam_pkg::F_CMD1_RANGE] = cmd1_out_of_range_i; // [RULE3]
    set_d[sfam_pkg::F_CMD2_RANGE] = cmd2_out_of_range_i | cmd_crosscheck_fail_i; // [RULE4]
    set_d[sfam_pkg::F_FB1_RANGE] = fb1_out_of_range_i; // [RULE5]
    set_d[sfam_pkg::F_FB2_RANGE] = fb2_out_of_range_i | fb_crosscheck_fail_i; // [RULE6]
    set_d[sfam_pkg::F_NMT_LATE] = nmt_expired; // [RULE7]
    set_d[sfam_pkg::F_NV_FAIL] = nv_fail_i; // [RULE8]
    set_d[sfam_pkg::F_PARAM_CHANGE] = param_change_i | param_restore_i; // [RULE9]
    set_d[sfam_pkg::F_INTLK_SUP] = interlock_sw_a_i ^ interlock_sw_b_i; // [RULE10]
    set_d[sfam_pkg::F_HOME_SW_SUP] = !near_home_i && (home_sw_a_i ^ home_sw_b_i); // [RULE11]
    set_d[sfam_pkg::F_HOME_NOT_FOUND] = home_not_found_i; // [RULE12]
    set_d[sfam_pkg::F_HOME_TOL] = home_tolerance_fail_i; // [RULE12]
    set_d[sfam_pkg::F_CMD_SUP] = cmd_supervision_fail_i; // [RULE13]
    set_d[sfam_pkg::F_POS_SUP] = pos_supervision_fail_i; // [RULE13]
    set_d[sfam_pkg::F_SW_FAULT] = software_fault_i; // [RULE14]
    set_d[sfam_pkg::F_PERIODIC_LOST] = pd_expired; // [RULE15]
    set_d[sfam_pkg::F_FOLLOW_ERR] = following_error_i; // [RULE16]
    set_d[sfam_pkg::F_HW_FAULT] = hardware_fault_i; // [RULE14]
    set_d[sfam_pkg::F_PARAM_CONFLICT] = param_conflict_i; // [RULE17]
    set_d[sfam_pkg::F_BUS_LOAD] = bus_overload_i; // [RULE18]
    set_d[sfam_pkg::F_PDO_MAP] = pdo_mapping_error_i; // [RULE19]
    set_d[sfam_pkg::F_BAD_CAL] = bad_calibration_i; // [RULE20]
    set_d[sfam_pkg::F_PARAM_RANGE] = param_out_of_range_i; // [RULE20]
    set_d[sfam_pkg::F_SUPERVISOR] = supervisor_fault_i; // [RULE14]
  end

  // Sticky latch of every fault; reset is the key switch power cycle.
  sfam_fault_latch #(
    .WIDTH(NF)
  ) u_latch ( // [RULE24]
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(set_d),
    .flag_o(flt_q)
  );

  // Action classes of the latched faults.
  assign any_shut = |(flt_q & sfam_pkg::SHUT_MASK);
  assign any_hold = |(flt_q & sfam_pkg::HOLD_MASK);
  assign any_warn = |(flt_q & sfam_pkg::WARN_MASK);

  // Millisecond enable pulse for the fault steering timeout.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_div_q <= 18'h00000;
      ms_tick_q <= 1'b0;
    end else if (ms_div_q == 18'(MS_CYCLES - 1)) begin
      ms_div_q <= 18'h00000;
      ms_tick_q <= 1'b1;
    end else begin
      ms_div_q <= ms_div_q + 18'h00001;
      ms_tick_q <= 1'b0;
    end
  end

  // Timeout count runs across warn and hold, so an escalation never restarts the grace period.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_ms_q <= 16'h0000;
    end else if (state_q == sfam_pkg::ST_NORMAL) begin
      act_ms_q <= 16'h0000;
    end else if (ms_tick_q && !act_timeout) begin
      act_ms_q <= act_ms_q + 16'h0001;
    end
  end

  assign act_timeout = (act_ms_q >= fault_steer_timeout_ms_i);

  // Steering action selection, most severe class first.
  always_comb begin
    state_d = state_q;
    case (state_q)
      sfam_pkg::ST_NORMAL: begin
        if (any_shut) begin
          state_d = sfam_pkg::ST_SHUTDOWN; // [RULE25]
        end else if (any_hold) begin
          state_d = sfam_pkg::ST_HOLD; // [RULE25]
        end else if (any_warn) begin
          state_d = sfam_pkg::ST_WARN;
        end
      end
      sfam_pkg::ST_WARN: begin
        if (any_shut || traction_stopped_i || act_timeout) begin
          state_d = sfam_pkg::ST_SHUTDOWN; // [RULE22]
        end else if (any_hold) begin
          state_d = sfam_pkg::ST_HOLD; // [RULE25]
        end
      end
      sfam_pkg::ST_HOLD: begin
        if (any_shut || traction_stopped_i || act_timeout) begin
          state_d = sfam_pkg::ST_SHUTDOWN; // [RULE23]
        end
      end
      sfam_pkg::ST_SHUTDOWN: begin
        state_d = sfam_pkg::ST_SHUTDOWN;
      end
      default: begin
        state_d = sfam_pkg::ST_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= sfam_pkg::ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // Reported code is that of the lowest-numbered active fault.
  always_comb begin
    code_d = sfam_pkg::NO_CODE;
    for (int i = NF - 1; i >= 0; i--) begin
      if (flt_q[i]) begin
        code_d = sfam_pkg::FLASH_CODES[i];
      end
    end
  end

  // Registered outputs, one cycle behind the action state.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      steer_enable_o <= 1'b0;
      hold_position_o <= 1'b0;
      fault_output_o <= 1'b0;
    end else begin
      steer_enable_o <= (state_q != sfam_pkg::ST_SHUTDOWN); // [RULE21]
      fault_output_o <= (state_q != sfam_pkg::ST_SHUTDOWN); // [RULE21]
      hold_position_o <= (state_q == sfam_pkg::ST_HOLD); // [RULE23]
    end
  end

  // Traction request, interlock gate and fault report.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interlock_enable_o <= 1'b0;
      traction_stop_req_o <= 1'b0;
      fault_active_o <= 1'b0;
      flash_code_o <= sfam_pkg::NO_CODE;
      fault_vector_o <= '0;
    end else begin
      interlock_enable_o <= intlk_applied && !(|(flt_q & sfam_pkg::INTLK_MASK)); // [RULE10]
      traction_stop_req_o <= |flt_q; // [RULE1] [RULE2] [RULE3] [RULE15]
      fault_active_o <= |flt_q;
      flash_code_o <= code_d; // [RULE24]
      fault_vector_o <= flt_q;
    end
  end

  // Checks on the fault detection, latch, action logic and outputs.
  sequence s_warn_release;
    (state_q == sfam_pkg::ST_WARN) && !any_hold && (traction_stopped_i || act_timeout);
  endsequence

  sequence s_shut_out;
    ##2 (!steer_enable_o && !fault_output_o);
  endsequence

  property p_shut_immediate;
    @(posedge sys_clk_i) disable iff (!reset_n_i) any_shut |-> s_shut_out;
  endproperty
  a_shut_immediate: assert property (p_shut_immediate) else $error("shutdown fault did not stop steering"); // [RULE21]

  property p_latch_sticky;
    @(posedge sys_clk_i) disable iff (!reset_n_i) ##1 ((flt_q & $past(flt_q)) == $past(flt_q));
  endproperty
  a_latch_sticky: assert property (p_latch_sticky) else $error("latched fault was cleared"); // [RULE24]

  property p_set_latches;
    @(posedge sys_clk_i) disable iff (!reset_n_i) (|set_d) |=> ((flt_q & $past(set_d)) == $past(set_d));
  endproperty
  a_set_latches: assert property (p_set_latches) else $error("fault request was not latched"); // [RULE2]

  property p_traction_stop;
    @(posedge sys_clk_i) disable iff (!reset_n_i) (|flt_q) |=> (traction_stop_req_o && fault_active_o);
  endproperty
  a_traction_stop: assert property (p_traction_stop) else $error("traction stop not requested"); // [RULE1]

  property p_warn_exit;
    @(posedge sys_clk_i) disable iff (!reset_n_i) s_warn_release |=> (state_q == sfam_pkg::ST_SHUTDOWN);
  endproperty
  a_warn_exit: assert property (p_warn_exit) else $error("warning state did not shut down"); // [RULE22]

  property p_hold_out;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (any_hold && !any_shut && !traction_stopped_i && (state_q == sfam_pkg::ST_NORMAL)) |=> ##1 hold_position_o;
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("hold fault did not freeze position"); // [RULE23]

  property p_intlk_off;
    @(posedge sys_clk_i) disable iff (!reset_n_i) flt_q[sfam_pkg::F_INTLK_SUP] |=> !interlock_enable_o;
  endproperty
  a_intlk_off: assert property (p_intlk_off) else $error("interlock not forced off"); // [RULE10]

  property p_home_masked;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (near_home_i && !flt_q[sfam_pkg::F_HOME_SW_SUP]) |=> !flt_q[sfam_pkg::F_HOME_SW_SUP];
  endproperty
  a_home_masked: assert property (p_home_masked) else $error("home check ran near home"); // [RULE11]

  property p_nmt_late;
    @(posedge sys_clk_i) disable iff (!reset_n_i) nmt_expired |=> flt_q[sfam_pkg::F_NMT_LATE];
  endproperty
  a_nmt_late: assert property (p_nmt_late) else $error("network start fault not raised"); // [RULE7]

  property p_code_shown;
    @(posedge sys_clk_i) disable iff (!reset_n_i) fault_active_o |-> (flash_code_o != sfam_pkg::NO_CODE);
  endproperty
  a_code_shown: assert property (p_code_shown) else $error("active fault without flash code"); // [RULE24]

endmodule

/* File: tb/sfam_far_side.sv */
`timescale 1ns/1ns
// Traction controller and network seen from the steering block; it drives at the falling edge.
module sfam_far_side (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic stop_req_i,
  input wire logic interlock_applied_i,
  input wire logic [15:0] stop_delay_i,
  input wire logic [7:0] msg_period_i,
  input wire logic [7:0] nmt_delay_i,
  output logic traction_stopped_o,
  output logic periodic_msg_o,
  output logic nmt_operational_o
);
  int stop_cnt;
  int msg_cnt;
  int nmt_cnt;

  // The traction motor coasts for a while after a stop request, so a slow stop is modelled too.
  always @(negedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_cnt = 0;
      msg_cnt = 0;
      nmt_cnt = 0;
      traction_stopped_o = 1'b0;
      periodic_msg_o = 1'b0;
      nmt_operational_o = 1'b0;
    end else begin
      stop_cnt = stop_req_i ? stop_cnt + 1 : 0;
      traction_stopped_o = stop_req_i && (stop_cnt >= int'(stop_delay_i));
      // A period of zero means the controller has gone silent; periods stay well above bus limits.
      msg_cnt = (msg_period_i == 8'h00 || msg_cnt + 1 >= int'(msg_period_i)) ? 0 : msg_cnt + 1;
      periodic_msg_o = (msg_period_i != 8'h00) && (msg_cnt == 0);
      // The network state goes operational some cycles after the interlock is applied.
      nmt_cnt = interlock_applied_i ? nmt_cnt + 1 : 0;
      nmt_operational_o = interlock_applied_i && (nmt_cnt >= int'(nmt_delay_i));
    end
  end
endmodule

/* File: tb/steer_fault_action_manager_tb.sv */
`timescale 1ns/1ns
module steer_fault_action_manager_tb;
  localparam logic [6:0] CODE [26] = '{7'h25, 7'h26, 7'h27, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f,
    7'h33, 7'h34, 7'h35, 7'h36, 7'h37, 7'h38, 7'h47, 7'h48, 7'h49, 7'h4a, 7'h4b, 7'h4e, 7'h4f, 7'h51, 7'h52, 7'h54};
  localparam logic [25:0] SHUT = 26'h3dd3306;
  localparam logic [25:0] HOLD_SET = 26'h000c078;
  logic sys_clk_i;
  logic reset_n;
  logic [25:0] flt;
  logic alt, ilk, home, near;
  logic [15:0] tmo, stop_dly;
  logic [7:0] period, nmt_dly;
  logic stopped, msg, nmt;
  logic steer_enable_o, hold_position_o, fault_output_o, interlock_enable_o, traction_stop_req_o, fault_active_o;
  logic [6:0] flash_code_o;
  logic [25:0] fault_vector_o;
  int err_count = 0;
  int n_checks = 0;

  sfam_manager #(.MS_CYCLES(10), .NMT_TIMEOUT_CYC(80), .PERIODIC_TIMEOUT_CYC(100)) i_sfam_manager (
    .sys_clk_i, .reset_n_i(reset_n), .motor_open_i(flt[0]), .relay_welded_i(flt[1]), .relay_no_close_i(flt[2]),
    .cmd1_out_of_range_i(flt[3]), .cmd2_out_of_range_i(flt[4] & !alt), .cmd_crosscheck_fail_i(flt[4] & alt),
    .fb1_out_of_range_i(flt[5]), .fb2_out_of_range_i(flt[6] & !alt), .fb_crosscheck_fail_i(flt[6] & alt),
    .nmt_operational_i(nmt), .nv_fail_i(flt[8]), .param_change_i(flt[9] & !alt), .param_restore_i(flt[9] & alt),
    .interlock_sw_a_i(ilk), .interlock_sw_b_i(ilk ^ flt[10]), .near_home_i(near), .home_sw_a_i(home),
    .home_sw_b_i(home ^ flt[11]), .home_not_found_i(flt[12]), .home_tolerance_fail_i(flt[13]),
    .cmd_supervision_fail_i(flt[14]), .pos_supervision_fail_i(flt[15]), .software_fault_i(flt[16]),
    .hardware_fault_i(flt[19]), .supervisor_fault_i(flt[25]), .traction_periodic_message_i(msg),
    .following_error_i(flt[18]), .param_conflict_i(flt[20]), .bus_overload_i(flt[21]),
    .pdo_mapping_error_i(flt[22]), .bad_calibration_i(flt[23]), .param_out_of_range_i(flt[24]),
    .traction_stopped_i(stopped), .fault_steer_timeout_ms_i(tmo), .steer_enable_o, .hold_position_o,
    .fault_output_o, .interlock_enable_o, .traction_stop_req_o, .fault_active_o, .flash_code_o, .fault_vector_o);

  sfam_far_side i_sfam_far_side (.sys_clk_i, .reset_n_i(reset_n), .stop_req_i(traction_stop_req_o),
    .interlock_applied_i(ilk & (ilk ^ flt[10])), .stop_delay_i(stop_dly), .msg_period_i(period),
    .nmt_delay_i(nmt_dly), .traction_stopped_o(stopped), .periodic_msg_o(msg), .nmt_operational_o(nmt));

  // Free-running 250 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic test_done();
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected flag at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // The lowest latched index owns the flash code.
  function automatic logic [6:0] exp_code(input logic [25:0] v);
    exp_code = 7'h00;
    for (int k = 25; k >= 0; k--) if (v[k]) exp_code = CODE[k];
  endfunction

  // Compares every output against the latched set; esc says a graceful action has run out.
  task automatic check_out(input logic [25:0] ev, input logic esc);
    logic shut;
    logic hold;
    shut = esc || |(ev & SHUT);
    hold = !shut && |(ev & HOLD_SET);
    chk_val(32'(fault_vector_o), 32'(ev));
    chk_val(32'(flash_code_o), 32'(exp_code(ev)));
    chk_bit(traction_stop_req_o, |ev);
    chk_bit(fault_active_o, |ev);
    chk_bit(steer_enable_o, !shut);
    chk_bit(fault_output_o, !shut);
    chk_bit(hold_position_o, hold);
    chk_bit(interlock_enable_o, ilk && !ev[10]);
  endtask

  // Power cycle: reset is asserted off the clock edge and held four cycles.
  task automatic do_reset(input logic ilk_v);
    reset_n = 1'b0;
    flt = '0;
    alt = 1'b0;
    ilk = ilk_v;
    home = 1'b0;
    near = 1'b0;
    tmo = 16'h03e8;
    nmt_dly = 8'h05;
    stop_dly = 16'(10 + $urandom % 31);
    repeat (4) @(negedge sys_clk_i);
    reset_n = 1'b1;
  endtask

  // Raises a set of fault inputs for one cycle and returns when every answer has landed.
  task automatic pulse(input logic [25:0] m);
    @(negedge sys_clk_i);
    flt = m;
    @(negedge sys_clk_i);
    flt = '0;
    repeat (3) @(negedge sys_clk_i);
  endtask

  // The whole run is at most about 2100 cycles; this limit only cuts a hang short.
  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    period = 8'h00;
    void'($urandom(12));
    do_reset(1'b1);
    repeat (150) @(negedge sys_clk_i);
    check_out('0, 1'b0);
    period = 8'h14;
    near = 1'b1;
    home = 1'($urandom);
    pulse(26'h0000800);
    near = 1'b0;
    check_out('0, 1'b0);
    // Each fault but 7 and 17 alone: code, action, then the graceful actions run out once traction stops.
    for (int i = 0; i < 26; i++) begin
      if (i == 7 || i == 17) continue;
      do_reset(1'b1);
      alt = 1'($urandom);
      home = 1'($urandom);
      pulse(26'h1 << i);
      check_out(26'h1 << i, 1'b0);
      repeat (int'(stop_dly) + 6) @(negedge sys_clk_i);
      check_out(26'h1 << i, i != 10 && !SHUT[i]);
    end
    // Hold with traction never stopping: the steering timeout alone ends it.
    do_reset(1'b1);
    stop_dly = 16'hffff;
    tmo = 16'(2 + $urandom % 4);
    pulse(26'h0000008);
    repeat (int'(tmo) * 10 - 13) @(negedge sys_clk_i);
    check_out(26'h0000008, 1'b0);
    repeat (20) @(negedge sys_clk_i);
    check_out(26'h0000008, 1'b1);
    // A zero timeout shuts down on the next cycle.
    do_reset(1'b1);
    stop_dly = 16'hffff;
    tmo = 16'h0000;
    pulse(26'h0200000);
    @(negedge sys_clk_i);
    check_out(26'h0200000, 1'b1);
    // Warning and hold together hold; a later shutdown fault overrides both.
    do_reset(1'b1);
    stop_dly = 16'hffff;
    pulse(26'h0004001);
    check_out(26'h0004001, 1'b0);
    pulse(26'h0080000);
    check_out(26'h0084001, 1'b0);
    // A hold fault that arrives while a warning runs escalates the warning to a hold.
    do_reset(1'b1);
    stop_dly = 16'hffff;
    pulse(26'h0000001);
    check_out(26'h0000001, 1'b0);
    pulse(26'h0008000);
    check_out(26'h0008001, 1'b0);
    // The network must go operational within 80 cycles of the interlock being applied.
    for (int late = 0; late < 2; late++) begin
      do_reset(1'b0);
      stop_dly = 16'hffff;
      nmt_dly = late ? 8'hc8 : 8'h28;
      @(negedge sys_clk_i);
      ilk = 1'b1;
      repeat (70) @(negedge sys_clk_i);
      check_out('0, 1'b0);
      repeat (30) @(negedge sys_clk_i);
      check_out(late ? 26'h0000080 : 26'h0, 1'b0);
    end
    // Periodic messages keep the watchdog quiet; silence latches the timeout.
    do_reset(1'b1);
    stop_dly = 16'hffff;
    repeat (150) @(negedge sys_clk_i);
    period = 8'h00;
    repeat (60) @(negedge sys_clk_i);
    check_out('0, 1'b0);
    repeat (60) @(negedge sys_clk_i);
    check_out(26'h0020000, 1'b0);
    test_done();
  end
endmodule
